// ===== hw/fsxa_top.v
// flash store control, key lock and on-chip data ram address mapping
`timescale 1ns/100ps
`include "fsxa_regs.vh"

module fsxa_top #(
  parameter FLASH_AW = 13
) (
  input  wire                CORE_CLK_I,
  input  wire                NRST_I,
  // special-function register port from the core, same clock
  input  wire                SFR_WR_I,
  input  wire                SFR_RD_I,
  input  wire [7:0]          SFR_ADDR_I,
  input  wire [7:0]          SFR_WDATA_I,
  output wire [7:0]          SFR_RDATA_O,
  // external-data move request from the core
  input  wire                XMOVE_WR_I,
  input  wire                XMOVE_RD_I,
  input  wire                XMOVE_SHORT_I,
  input  wire [15:0]         XMOVE_ADDR_I,
  input  wire [7:0]          XMOVE_WDATA_I,
  output wire [7:0]          XMOVE_RDATA_O,
  // flash macro command side
  output wire                FLASH_PROG_O,
  output wire                FLASH_ERASE_O,
  output wire [FLASH_AW-1:0] FLASH_ADDR_O,
  output wire [7:0]          FLASH_WDATA_O,
  output wire                READ_ONE_SHOT_EN_O,
  output wire [1:0]          LOCK_STATE_O
);

  localparam RAM_DEPTH = 512;

  // storage overview:
  //   psc_reg holds only the two live enable bits of program store control
  //   data_ram_page_select_reg is the single live bit of the page control register
  //   one_shot_reg is the only live bit of flash scale
  //   lock_reg is the two-bit key sequencer state, also the key register read value
  // the flash array itself sits outside; this block only issues one-cycle commands

  reg [1:0]          psc_reg;
  reg                data_ram_page_select_reg;
  reg                one_shot_reg;
  reg [1:0]          lock_reg;
  reg [1:0]          lock_next;
  reg [7:0]          rdata_reg;
  reg [7:0]          xrdata_reg;
  reg                prog_reg;
  reg                erase_reg;
  reg [FLASH_AW-1:0] faddr_reg;
  reg [7:0]          fwdata_reg;
  reg [7:0]          ram [0:RAM_DEPTH-1];

  // request decode; the register port and the move port share the core clock,
  // so no synchroniser is needed on either of them
  // a move write counts as a flash attempt whenever the write enable is set,
  // whatever the lock state: the sequencer decides whether it is honoured
  wire       key_wr   = SFR_WR_I && (SFR_ADDR_I == `FSXA_KEY_ADDR);
  wire       wr_en    = psc_reg[`FSXA_WE_BIT];
  wire       er_en    = psc_reg[`FSXA_EE_BIT];
  wire       flash_wr = XMOVE_WR_I && wr_en;
  // short moves take address bit 8 from the page bit, long ones drop the top seven bits
  wire [8:0] ram_addr = XMOVE_SHORT_I ? {data_ram_page_select_reg, XMOVE_ADDR_I[7:0]}
                                      : XMOVE_ADDR_I[8:0];

  // control registers; reserved bits are never stored so they read zero
  always @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      psc_reg      <= 2'h0;
      data_ram_page_select_reg    <= 1'b0;
      one_shot_reg <= 1'b1;
    end else if (SFR_WR_I) begin
      if (SFR_ADDR_I == `FSXA_PSC_ADDR) begin
        psc_reg <= SFR_WDATA_I[1:0];
      end
      if (SFR_ADDR_I == `FSXA_EMP_ADDR) begin
        data_ram_page_select_reg <= SFR_WDATA_I[`FSXA_DATA_RAM_PAGE_SELECT_BIT];
      end
      if (SFR_ADDR_I == `FSXA_FSC_ADDR) begin
        one_shot_reg <= SFR_WDATA_I[`FSXA_OSE_BIT];
      end
    end
  end

  // key lock sequencer; any misstep drops into the dead state that only reset leaves
  // other register writes between the two keys are allowed, only key writes advance it
  // a flash attempt takes priority over a key write in the same cycle, since the
  // attempt alone already decides the outcome in every state but the dead one
  // a key write while open is treated as a wrong key, trading leniency for safety
  always @* begin
    lock_next = lock_reg;
    case (lock_reg)
      `FSXA_LK_LOCKED: begin
        if (flash_wr) begin
          lock_next = `FSXA_LK_DEAD;
        end else if (key_wr) begin
          lock_next = (SFR_WDATA_I == `FSXA_KEY_FIRST) ? `FSXA_LK_FIRST : `FSXA_LK_DEAD;
        end
      end
      `FSXA_LK_FIRST: begin
        if (flash_wr) begin
          lock_next = `FSXA_LK_DEAD;
        end else if (key_wr) begin
          lock_next = (SFR_WDATA_I == `FSXA_KEY_SECOND) ? `FSXA_LK_OPEN : `FSXA_LK_DEAD;
        end
      end
      `FSXA_LK_OPEN: begin
        if (flash_wr) begin
          lock_next = `FSXA_LK_LOCKED;
        end else if (key_wr) begin
          lock_next = `FSXA_LK_DEAD;
        end
      end
      `FSXA_LK_DEAD: begin
        lock_next = `FSXA_LK_DEAD;
      end
      default: begin
        lock_next = `FSXA_LK_DEAD;
      end
    endcase
  end

  // lock state register; reset is the only way out of the dead state
  always @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lock_reg <= `FSXA_LK_LOCKED;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // flash command strobes, one cycle, only from the unlocked state
  // the strobe itself is taken as completion, so the lock returns in the same cycle;
  // a slower macro must latch address and data at the strobe, they hold until the next one
  always @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prog_reg   <= 1'b0;
      erase_reg  <= 1'b0;
      faddr_reg  <= {FLASH_AW{1'b0}};
      fwdata_reg <= 8'h00;
    end else begin
      prog_reg  <= flash_wr && !er_en && (lock_reg == `FSXA_LK_OPEN);
      erase_reg <= flash_wr && er_en && (lock_reg == `FSXA_LK_OPEN);
      if (flash_wr && (lock_reg == `FSXA_LK_OPEN)) begin
        // erase address aligned down to its 512-byte page
        faddr_reg  <= er_en ? {XMOVE_ADDR_I[FLASH_AW-1:9], 9'h000}
                            : XMOVE_ADDR_I[FLASH_AW-1:0];
        fwdata_reg <= er_en ? 8'hFF : XMOVE_WDATA_I; // data ignored on erase
      end
    end
  end

  // data ram; writes land here unless redirected to flash, reads always come here
  // contents are not reset, software must initialise what it reads
  // a write with write enable set never reaches the ram, even when the lock refuses it
  always @(posedge CORE_CLK_I) begin
    if (XMOVE_WR_I && !wr_en) begin
      ram[ram_addr] <= XMOVE_WDATA_I;
    end
  end

  // move read data, registered, holds until the next move read
  always @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      xrdata_reg <= 8'h00;
    end else if (XMOVE_RD_I) begin
      xrdata_reg <= ram[ram_addr];
    end
  end

  // register read mux, registered; unmapped addresses read zero
  // read data stands from the edge after the read strobe until the next read
  always @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_reg <= 8'h00;
    end else if (SFR_RD_I) begin
      case (SFR_ADDR_I)
        `FSXA_PSC_ADDR: rdata_reg <= {6'h00, psc_reg};
        `FSXA_EMP_ADDR: rdata_reg <= {7'h00, data_ram_page_select_reg};
        `FSXA_FSC_ADDR: rdata_reg <= {one_shot_reg, 7'h00};
        `FSXA_KEY_ADDR: rdata_reg <= {6'h00, lock_reg};
        default:        rdata_reg <= 8'h00;
      endcase
    end
  end

  // every output is a plain flip-flop copy, no logic after the registers
  assign SFR_RDATA_O        = rdata_reg;
  assign XMOVE_RDATA_O      = xrdata_reg;
  assign FLASH_PROG_O       = prog_reg;
  assign FLASH_ERASE_O      = erase_reg;
  assign FLASH_ADDR_O       = faddr_reg;
  assign FLASH_WDATA_O      = fwdata_reg;
  assign READ_ONE_SHOT_EN_O = one_shot_reg; // off keeps sense amps on a full cycle
  assign LOCK_STATE_O       = lock_reg;

endmodule // fsxa_top

// ===== hw/fsxa_regs.vh
// register offsets, field positions, reset values and key codes for the flash store and data ram access block
`ifndef FSXA_REGS_VH
`define FSXA_REGS_VH
`define FSXA_PSC_ADDR      8'h8F
`define FSXA_EMP_ADDR      8'hAA
`define FSXA_FSC_ADDR      8'hB6
`define FSXA_KEY_ADDR      8'hB7
`define FSXA_PSC_RESET     8'h00
`define FSXA_EMP_RESET     8'h00
`define FSXA_FSC_RESET     8'h80
`define FSXA_WE_BIT        0
`define FSXA_EE_BIT        1
`define FSXA_OSE_BIT       7
`define FSXA_DATA_RAM_PAGE_SELECT_BIT     0
`define FSXA_KEY_FIRST     8'hA5
`define FSXA_KEY_SECOND    8'hF1
`define FSXA_LK_LOCKED     2'h0
`define FSXA_LK_FIRST      2'h1
`define FSXA_LK_OPEN       2'h2
`define FSXA_LK_DEAD       2'h3
`endif

// ===== tb/fsxa_checker.sv
// assertion checker bound to the flash store and data ram access block
`timescale 1ns/100ps
module fsxa_checker #(parameter FLASH_AW = 13) (
  input wire                CORE_CLK_I, NRST_I, SFR_WR_I, SFR_RD_I, XMOVE_WR_I,
  input wire                FLASH_PROG_O, FLASH_ERASE_O, READ_ONE_SHOT_EN_O,
  input wire [7:0]          SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O, FLASH_WDATA_O,
  input wire [FLASH_AW-1:0] FLASH_ADDR_O,
  input wire [1:0]          LOCK_STATE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  // either flash command counts as the one operation an unlock buys
  wire cmd = FLASH_PROG_O | FLASH_ERASE_O;
  a_single_cmd: assert property (!(FLASH_PROG_O && FLASH_ERASE_O)) else $error("prog and erase together");
  a_erase_aligned: assert property (FLASH_ERASE_O |-> FLASH_ADDR_O[8:0] == 9'h000) else $error("erase misaligned");
  a_cmd_when_open: assert property (cmd |-> $past(XMOVE_WR_I) && $past(LOCK_STATE_O) == 2'h2)
    else $error("flash command while locked");
  a_relock_after: assert property (cmd |-> LOCK_STATE_O == 2'h0) else $error("no relock after command");
  a_dead_sticks: assert property (LOCK_STATE_O == 2'h3 |=> LOCK_STATE_O == 2'h3) else $error("dead lock left");
  a_first_key: assert property ($past(LOCK_STATE_O) == 2'h0 && LOCK_STATE_O == 2'h1 |-> $past(SFR_WDATA_I) == 8'hA5)
    else $error("first key wrong");
  a_second_key: assert property ($past(LOCK_STATE_O) == 2'h1 && LOCK_STATE_O == 2'h2 |-> $past(SFR_WDATA_I) == 8'hF1)
    else $error("second key wrong");
  a_key_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'hB7 |=> SFR_RDATA_O == {6'h00, $past(LOCK_STATE_O)})
    else $error("key read wrong");
  a_psc_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'h8F |=> SFR_RDATA_O[7:2] == 6'h00)
    else $error("store control upper bits");
  a_scale_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'hB6 |=> SFR_RDATA_O == {$past(READ_ONE_SHOT_EN_O), 7'h00})
    else $error("scale read wrong");
  a_page_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'hAA |=> SFR_RDATA_O[7:1] == 7'h00)
    else $error("page upper bits");
endmodule // fsxa_checker
bind fsxa_top fsxa_checker #(.FLASH_AW(FLASH_AW)) i_chk (.*);

// ===== tb/fsxa_flash_model.sv
// flash array model behind the command port of the block
`timescale 1ns/100ps
module fsxa_flash_model #(parameter AW = 13) (
  input wire          clk_i, prog_i, erase_i,
  input wire [AW-1:0] addr_i,
  input wire [7:0]    wdata_i,
  output reg [7:0]    overwrite_o
);
  reg [7:0] mem [0:(1<<AW)-1];
  integer   i;
  initial begin
    overwrite_o = 8'h00;
    for (i = 0; i < (1 << AW); i = i + 1) mem[i] = 8'hFF;
  end
  // cells only pull bits low on program, so an unerased target is counted as misuse
  always @(posedge clk_i) begin
    if (erase_i) for (i = 0; i < 512; i = i + 1) mem[{addr_i[AW-1:9], 9'h000} + i] = 8'hFF;
    if (prog_i) begin
      if (mem[addr_i] !== 8'hFF) overwrite_o = overwrite_o + 8'h01;
      mem[addr_i] = mem[addr_i] & wdata_i;
    end
  end
endmodule // fsxa_flash_model

// ===== tb/flash_store_and_on_chip_data_ram_access_test.sv
// self-checking bench for the flash store and data ram access block
`timescale 1ns/100ps
module flash_store_and_on_chip_data_ram_access_test;
  reg        CORE_CLK_I = 0, NRST_I = 0, SFR_WR_I = 0, SFR_RD_I = 0, XMOVE_WR_I = 0, XMOVE_RD_I = 0, XMOVE_SHORT_I = 0;
  reg [7:0]  SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, XMOVE_WDATA_I = 8'h00;
  reg [15:0] XMOVE_ADDR_I = 16'h0000;
  wire [7:0] SFR_RDATA_O, XMOVE_RDATA_O, FLASH_WDATA_O, ovw;
  wire [12:0] FLASH_ADDR_O;
  wire       FLASH_PROG_O, FLASH_ERASE_O, READ_ONE_SHOT_EN_O;
  wire [1:0] LOCK_STATE_O;
  integer    n_errors = 0, check_count = 0;
  always #4 CORE_CLK_I = ~CORE_CLK_I;
  fsxa_top #(.FLASH_AW(13)) i_dut (.*);
  fsxa_flash_model #(.AW(13)) i_fl (.clk_i(CORE_CLK_I), .prog_i(FLASH_PROG_O), .erase_i(FLASH_ERASE_O),
    .addr_i(FLASH_ADDR_O), .wdata_i(FLASH_WDATA_O), .overwrite_o(ovw));
  task ck(input string n, input [7:0] e, input [7:0] g); begin
    check_count = check_count + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0s expected %h seen %h", n, e, g);
    end
  end endtask
  // every strobe is raised on a falling edge and dropped on the next, so it is sampled once
  task wr(input [7:0] a, input [7:0] d); begin
    @(negedge CORE_CLK_I); SFR_WR_I = 1; SFR_ADDR_I = a; SFR_WDATA_I = d;
    @(negedge CORE_CLK_I); SFR_WR_I = 0;
  end endtask
  task rd(input [7:0] a, input [7:0] e); begin
    @(negedge CORE_CLK_I); SFR_RD_I = 1; SFR_ADDR_I = a;
    @(negedge CORE_CLK_I); SFR_RD_I = 0; ck("register", e, SFR_RDATA_O);
  end endtask
  task mv(input s, input [15:0] a, input [7:0] d); begin
    @(negedge CORE_CLK_I); XMOVE_WR_I = 1; XMOVE_SHORT_I = s; XMOVE_ADDR_I = a; XMOVE_WDATA_I = d;
    @(negedge CORE_CLK_I); XMOVE_WR_I = 0;
  end endtask
  task mr(input s, input [15:0] a, input [7:0] e); begin
    @(negedge CORE_CLK_I); XMOVE_RD_I = 1; XMOVE_SHORT_I = s; XMOVE_ADDR_I = a;
    @(negedge CORE_CLK_I); XMOVE_RD_I = 0; ck("ram", e, XMOVE_RDATA_O);
  end endtask
  task end_of_test; begin
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  // a hung run still reaches the verdict
  initial begin
    #400000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (10) @(negedge CORE_CLK_I);
    NRST_I = 1;
    rd(8'h8F, 8'h00); rd(8'hAA, 8'h00); rd(8'hB6, 8'h80); rd(8'hB7, 8'h00); rd(8'h55, 8'h00);
    wr(8'h8F, 8'hFF); rd(8'h8F, 8'h03); wr(8'hAA, 8'hFF); rd(8'hAA, 8'h01);
    wr(8'hB6, 8'h00); rd(8'hB6, 8'h00); ck("one_shot", 8'h00, {7'h00, READ_ONE_SHOT_EN_O});
    wr(8'hB6, 8'h80); wr(8'h8F, 8'h00);
    $display("registers done");
    mv(1, 16'hFF34, 8'h5A); mr(0, 16'h0134, 8'h5A);
    mv(0, 16'hFE10, 8'hC3); wr(8'hAA, 8'h00); mr(1, 16'h0010, 8'hC3);
    mv(0, 16'h0034, 8'h11);
    $display("ram done");
    wr(8'h8F, 8'h01); wr(8'hB7, 8'hA5); rd(8'hB7, 8'h01); wr(8'hB7, 8'hF1); rd(8'hB7, 8'h02);
    mv(0, 16'h0234, 8'h3C); rd(8'hB7, 8'h00); mr(0, 16'h0234, 8'h11);
    ck("flash", 8'h3C, i_fl.mem[13'h0234]);
    wr(8'h8F, 8'h03); wr(8'hB7, 8'hA5); wr(8'hB7, 8'hF1); mv(0, 16'h03FF, 8'h00);
    // the erase strobe stands one cycle after the move, the array clears at the edge after that
    @(negedge CORE_CLK_I);
    ck("erased", 8'hFF, i_fl.mem[13'h0234]);
    wr(8'h8F, 8'h01); wr(8'hB7, 8'hA5); wr(8'hB7, 8'hF1); mv(0, 16'h0400, 8'h77);
    wr(8'h8F, 8'h03); mv(0, 16'h0500, 8'h00); rd(8'hB7, 8'h03);
    ck("kept", 8'h77, i_fl.mem[13'h0400]); ck("overwrite", 8'h00, ovw);
    wr(8'hB7, 8'hA5); wr(8'hB7, 8'hF1); rd(8'hB7, 8'h03);
    $display("flash done");
    NRST_I = 0;
    repeat (10) @(negedge CORE_CLK_I);
    NRST_I = 1;
    rd(8'hB7, 8'h00); wr(8'hB7, 8'h12); rd(8'hB7, 8'h03);
    $display("relock done");
    end_of_test;
  end
endmodule // flash_store_and_on_chip_data_ram_access_test
